// file: hw/usb_irq_flags_pkg.sv
// constants of the usb device interrupt flag block: offsets, field positions, resets
// assumes a 32-bit avalon-mm slave with byte addresses and one system clock
package usb_irq_flags_pkg;

    localparam int          ADDR_W         = 10;
    localparam int          NUM_EP         = 4;

    // ************************************************************
    // register byte offsets
    // ************************************************************
    localparam logic [9:0]  OFF_MAIN       = 10'h220;
    localparam logic [9:0]  OFF_EP_DONE    = 10'h224;
    localparam logic [9:0]  OFF_EP_MASK    = 10'h228;
    localparam logic [9:0]  OFF_ZERO_LEN   = 10'h22C;
    localparam logic [9:0]  OFF_NAK        = 10'h330;
    localparam logic [9:0]  OFF_NAK_MASK   = 10'h334;

    // ************************************************************
    // main register flag positions (masks sit 8 bits higher)
    // ************************************************************
    localparam int          BIT_SETUP      = 0;
    localparam int          BIT_STATUS_NAK = 1;
    localparam int          BIT_STATUS     = 2;
    localparam int          BIT_ZERO_LEN   = 3;
    localparam int          BIT_SOF        = 4;
    localparam int          BIT_EP0        = 5;
    localparam int          BIT_EP_DONE    = 6;
    localparam int          BIT_NAK        = 7;
    localparam int          MASK_SHIFT     = 8;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0]  RST_MAIN_MASK  = 8'h00;
    localparam logic [3:0]  RST_EP_MASK    = 4'h1;
    localparam logic [3:1]  RST_NAK_MASK   = 3'h0;
    localparam logic [31:0] RST_RDATA      = 32'h0000_0000;

endpackage : usb_irq_flags_pkg

// file: hw/usb_device_irq_flags.sv
// interrupt flag and mask logic of a usb device controller, with avalon-mm register port
// assumes event inputs are one-cycle pulses synchronous to core_clk from the protocol engine
//
// What this block does
// - set nak summary when any non-zero endpoint sends a nak handshake
// - writing one to nak summary clears all per-endpoint nak bits
// - set endpoint-done summary when an unmasked non-zero endpoint transfer completes
// - writing one to endpoint-done summary clears all per-endpoint done bits
// - zero-length packet on an unmasked endpoint sets zero-length summary; writing one clears per-endpoint bits
// - zero-length packet in control-read status stage does not set zero-length flags
// - set status-done flag when endpoint-zero status stage completes
// - set status-token flag on status packet during control read
// - data stage of exact 64-byte multiple may end with zero-length packet
// - one done bit per endpoint three to one, set on successful transfer
// - per-endpoint done bit cleared by writing one, zero leaves it
// - masked endpoint still sets done bit but not done interrupt output
// - masked endpoint still sets zero-length bit but not zero-length output
// - mask bit zero affects only the endpoint-zero zero-length path
// - mask bit zero resets to one; software clears it to enable
// - mask bit zero forwards flag to output, one blocks it
// - single unmasked endpoint: summary done flag mirrors its own done bit
// - main register low byte flags clear by one, high byte output masks
//
// Register access over Avalon-MM was decided locally.
`timescale 1ns/10ps
`default_nettype none

module usb_device_irq_flags
    import usb_irq_flags_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              nrst,
    // avalon-mm slave
    input  wire logic [ADDR_W-1:0] address,
    input  wire logic              read,
    input  wire logic              write,
    input  wire logic [3:0]        byteenable,
    input  wire logic [31:0]       writedata,
    output logic      [31:0]       readdata,
    output logic                   waitrequest,
    // protocol engine events
    input  wire logic              ev_setup,
    input  wire logic              ev_status_token,
    input  wire logic              ev_status_done,
    input  wire logic              ev_sof,
    input  wire logic              ev_ep0_done,
    input  wire logic [3:1]        ev_ep_done,
    input  wire logic [3:0]        ev_zero_len,
    input  wire logic              ctrl_rd_status_stage,
    input  wire logic [3:1]        ev_nak,
    // interrupt outputs
    output logic                   irq_setup,
    output logic                   irq_status_token,
    output logic                   irq_status_done,
    output logic                   irq_zero_len,
    output logic                   irq_sof,
    output logic                   irq_ep0,
    output logic                   ep_done_irq_out,
    output logic                   irq_nak
);

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic [7:0]  main_mask;
        logic        setup_flag;
        logic        status_token_flag;
        logic        status_done_flag;
        logic        sof_flag;
        logic        ep0_flag;
        logic [3:1]  ep_done_bits;
        logic [3:0]  ep_mask_bits;
        logic [3:0]  zero_len_bits;
        logic [3:1]  nak_bits;
        logic [3:1]  nak_mask_bits;
        logic        ack;
        logic [31:0] rdata;
        logic [7:0]  irq;
    } state_s;

    state_s st_reg;
    state_s st_next;

    // ************************************************************
    // helpers
    // ************************************************************
    // set beats clear so an event in the clearing cycle survives
    function automatic logic [3:0] w1c_set(input logic [3:0] q,
                                           input logic [3:0] clr,
                                           input logic [3:0] set);
        w1c_set = (q & ~clr) | set;
    endfunction : w1c_set

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [9:0] off);
        hit = (a[ADDR_W-1:2] == off[ADDR_W-1:2]);
    endfunction : hit

    // one-hot register select, shared by the write and the read path
    typedef struct packed {
        logic main;
        logic done;
        logic mask;
        logic zl;
        logic nak;
        logic nmask;
    } sel_s;

    function automatic sel_s decode(input logic [ADDR_W-1:0] a);
        decode       = '0;
        decode.main  = hit(a, OFF_MAIN);
        decode.done  = hit(a, OFF_EP_DONE);
        decode.mask  = hit(a, OFF_EP_MASK);
        decode.zl    = hit(a, OFF_ZERO_LEN);
        decode.nak   = hit(a, OFF_NAK);
        decode.nmask = hit(a, OFF_NAK_MASK);
    endfunction : decode

    // reserved bits and unmapped locations read as zero
    function automatic logic [31:0] read_word(input state_s     s,
                                              input sel_s       sel,
                                              input logic [7:0] flags);
        read_word = 32'h0000_0000;
        if (sel.main) begin
            read_word[15:0] = {s.main_mask, flags};
        end else if (sel.done) begin
            read_word[3:1] = s.ep_done_bits;
        end else if (sel.mask) begin
            read_word[3:0] = s.ep_mask_bits;
        end else if (sel.zl) begin
            read_word[3:0] = s.zero_len_bits;
        end else if (sel.nak) begin
            read_word[3:1] = s.nak_bits;
        end else if (sel.nmask) begin
            read_word[3:1] = s.nak_mask_bits;
        end
    endfunction : read_word

    // summary bits derive from per-endpoint bits, so both views always agree
    function automatic logic [7:0] main_flags(input state_s s);
        main_flags                 = 8'h00;
        main_flags[BIT_SETUP]      = s.setup_flag;
        main_flags[BIT_STATUS_NAK] = s.status_token_flag;
        main_flags[BIT_STATUS]     = s.status_done_flag;
        main_flags[BIT_ZERO_LEN]   = |(s.zero_len_bits & ~s.ep_mask_bits);
        main_flags[BIT_SOF]        = s.sof_flag;
        main_flags[BIT_EP0]        = s.ep0_flag;
        main_flags[BIT_EP_DONE]    = |(s.ep_done_bits & ~s.ep_mask_bits[3:1]);
        main_flags[BIT_NAK]        = |s.nak_bits;
    endfunction : main_flags

    // ************************************************************
    // bus decode
    // ************************************************************
    logic        req;
    logic        wr_go;
    logic [15:0] wmask;
    logic [15:0] wclr;
    logic [3:0]  zl_set;
    logic [7:0]  flags_now;

    assign req         = read | write;
    assign waitrequest = req & ~st_reg.ack;
    assign wr_go       = write & st_reg.ack;
    assign wmask       = {{8{byteenable[1]}}, {8{byteenable[0]}}};
    assign wclr        = writedata[15:0] & wmask;
    assign flags_now   = main_flags(st_reg);

    // ep0 zero-length in control-read status stage reports as status done only
    assign zl_set = {ev_zero_len[3:1], ev_zero_len[0] & ~ctrl_rd_status_stage};

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        sel_s       sel;
        logic       w_main;
        logic       w_done;
        logic       w_mask;
        logic       w_zl;
        logic       w_nak;
        logic       w_nmask;
        logic [7:0] c_main;
        logic [7:0] f;
        logic [3:0] done_v;
        logic [3:0] nak_v;
        f       = 8'h00;
        done_v  = 4'h0;
        nak_v   = 4'h0;
        sel     = decode(address);
        w_main  = wr_go & sel.main;
        w_done  = wr_go & sel.done;
        w_mask  = wr_go & sel.mask;
        w_zl    = wr_go & sel.zl;
        w_nak   = wr_go & sel.nak;
        w_nmask = wr_go & sel.nmask;
        c_main  = w_main ? wclr[7:0] : 8'h00;
        st_next = st_reg;

        // ************************************************************
        // main register
        // ************************************************************

        // main register: low byte write-one-clear, high byte masks
        if (w_main) begin
            st_next.main_mask = (st_reg.main_mask & ~wmask[15:8])
                              | (writedata[15:8] & wmask[15:8]);
        end
        st_next.setup_flag        = (st_reg.setup_flag & ~c_main[BIT_SETUP]) | ev_setup;
        st_next.status_token_flag = (st_reg.status_token_flag & ~c_main[BIT_STATUS_NAK])
                                  | ev_status_token;
        st_next.status_done_flag  = (st_reg.status_done_flag & ~c_main[BIT_STATUS])
                                  | ev_status_done;
        st_next.sof_flag          = (st_reg.sof_flag & ~c_main[BIT_SOF]) | ev_sof;
        st_next.ep0_flag          = (st_reg.ep0_flag & ~c_main[BIT_EP0]) | ev_ep0_done;

        // per-endpoint done bits: cleared per bit or all at once via summary
        // ************************************************************
        // per-endpoint flag registers
        // ************************************************************
        // endpoint zero has no done or nak bit, so slot 0 is padded and dropped
        done_v = w1c_set({st_reg.ep_done_bits, 1'b0},
                         {(w_done ? wclr[3:1] : 3'h0)
                          | {3{c_main[BIT_EP_DONE]}}, 1'b0},
                         {ev_ep_done, 1'b0});
        st_next.ep_done_bits = done_v[3:1];

        st_next.zero_len_bits = w1c_set(st_reg.zero_len_bits,
                                        (w_zl ? wclr[3:0] : 4'h0)
                                        | {4{c_main[BIT_ZERO_LEN]}},
                                        zl_set);

        nak_v = w1c_set({st_reg.nak_bits, 1'b0},
                        {(w_nak ? wclr[3:1] : 3'h0)
                         | {3{c_main[BIT_NAK]}}, 1'b0},
                        {ev_nak, 1'b0});
        st_next.nak_bits = nak_v[3:1];

        // ************************************************************
        // mask registers
        // ************************************************************

        if (w_mask) begin
            st_next.ep_mask_bits = (st_reg.ep_mask_bits & ~wmask[3:0])
                                 | (writedata[3:0] & wmask[3:0]);
        end
        if (w_nmask) begin
            st_next.nak_mask_bits = (st_reg.nak_mask_bits & ~wmask[3:1])
                                  | (writedata[3:1] & wmask[3:1]);
        end

        // ************************************************************
        // interrupt outputs
        // ************************************************************
        // outputs follow the flags being stored this cycle
        f = main_flags(st_next);
        f[BIT_NAK] = |(st_next.nak_bits & ~st_next.nak_mask_bits);
        st_next.irq = f & ~st_next.main_mask;

        // ************************************************************
        // bus handshake and read data
        // ************************************************************
        // one wait cycle, then read data stands while waitrequest is low;
        // a fixed wait keeps the slave simple at the cost of one cycle per access
        st_next.ack   = req & ~st_reg.ack;
        st_next.rdata = st_reg.rdata;
        if (req & ~st_reg.ack) begin
            st_next.rdata = read ? read_word(st_reg, sel, flags_now) : 32'h0000_0000;
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            st_reg                   <= '0;
            st_reg.main_mask         <= RST_MAIN_MASK;
            st_reg.ep_mask_bits      <= RST_EP_MASK;
            st_reg.nak_mask_bits     <= RST_NAK_MASK;
            st_reg.rdata             <= RST_RDATA;
        end else begin
            st_reg <= st_next;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign readdata         = st_reg.rdata;
    assign irq_setup        = st_reg.irq[BIT_SETUP];
    assign irq_status_token = st_reg.irq[BIT_STATUS_NAK];
    assign irq_status_done  = st_reg.irq[BIT_STATUS];
    assign irq_zero_len     = st_reg.irq[BIT_ZERO_LEN];
    assign irq_sof          = st_reg.irq[BIT_SOF];
    assign irq_ep0          = st_reg.irq[BIT_EP0];
    assign ep_done_irq_out  = st_reg.irq[BIT_EP_DONE];
    assign irq_nak          = st_reg.irq[BIT_NAK];

endmodule : usb_device_irq_flags

`default_nettype wire

// file: verification/usb_engine_model.sv
// protocol engine stand-in: raises one-cycle event pulses and the status-stage level
// assumes the bench calls its tasks from a process synchronous to core_clk
`timescale 1ns/10ps
`default_nettype none
module usb_engine_model (
    input  wire logic       core_clk,
    output logic            ev_setup,
    output logic            ev_status_token,
    output logic            ev_status_done,
    output logic            ev_sof,
    output logic            ev_ep0_done,
    output logic [3:1]      ev_ep_done,
    output logic [3:0]      ev_zero_len,
    output logic            ctrl_rd_status_stage,
    output logic [3:1]      ev_nak
);
    initial begin
        {ev_nak, ev_zero_len, ev_ep_done, ev_ep0_done, ev_sof} = '0;
        {ev_status_done, ev_status_token, ev_setup, ctrl_rd_status_stage} = '0;
    end
    // pulses last exactly one cycle, as the engine never holds an event
    task automatic send(input logic [14:0] v);
        @(posedge core_clk);
        {ev_nak, ev_zero_len, ev_ep_done, ev_ep0_done, ev_sof} <= v[14:3];
        {ev_status_done, ev_status_token, ev_setup} <= v[2:0];
        @(posedge core_clk);
        {ev_nak, ev_zero_len, ev_ep_done, ev_ep0_done, ev_sof} <= '0;
        {ev_status_done, ev_status_token, ev_setup} <= '0;
    endtask : send
    task automatic stage(input logic s);
        @(posedge core_clk);
        ctrl_rd_status_stage <= s;
    endtask : stage
endmodule : usb_engine_model
`default_nettype wire

// file: verification/usb_device_irq_flags_sva.sv
// port assertions for the usb interrupt flag block
// assumes one clock domain; bound to the block below
`timescale 1ns/10ps
`default_nettype none
module usb_device_irq_flags_sva (
    input wire logic        core_clk,
    input wire logic        nrst,
    input wire logic        read,
    input wire logic        write,
    input wire logic        waitrequest,
    input wire logic [31:0] readdata,
    input wire logic [3:1]  ev_ep_done,
    input wire logic [3:0]  ev_zero_len,
    input wire logic [3:1]  ev_nak,
    input wire logic        ev_status_done,
    input wire logic        ev_status_token,
    input wire logic        ctrl_rd_status_stage,
    input wire logic        ep_done_irq_out,
    input wire logic        irq_zero_len,
    input wire logic        irq_nak,
    input wire logic        irq_status_done,
    input wire logic        irq_status_token
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    property p_one_wait; (read || write) && waitrequest |=> !waitrequest; endproperty
    a_one_wait: assert property (p_one_wait) else $error("request waited over one cycle");
    property p_upper_zero; read && !waitrequest |-> readdata[31:16] == 16'h0000; endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
    property p_done_rise; $rose(ep_done_irq_out) |-> $past(ev_ep_done) != 3'h0 || $past(write);
    endproperty
    a_done_rise: assert property (p_done_rise) else $error("done output rose without cause");
    property p_zl_rise; $rose(irq_zero_len) |-> $past(ev_zero_len) != 4'h0 || $past(write);
    endproperty
    a_zl_rise: assert property (p_zl_rise) else $error("zero-length output rose without cause");
    property p_nak_rise; $rose(irq_nak) |-> $past(ev_nak) != 3'h0 || $past(write); endproperty
    a_nak_rise: assert property (p_nak_rise) else $error("nak output rose without cause");
    property p_sd_rise; $rose(irq_status_done) |-> $past(ev_status_done) || $past(write);
    endproperty
    a_sd_rise: assert property (p_sd_rise) else $error("status-done rose without cause");
    property p_tok_rise; $rose(irq_status_token) |-> $past(ev_status_token) || $past(write);
    endproperty
    a_tok_rise: assert property (p_tok_rise) else $error("status-token rose without cause");
    property p_done_hold; $fell(ep_done_irq_out) |-> $past(write); endproperty
    a_done_hold: assert property (p_done_hold) else $error("done output fell on its own");
    property p_stage_zl;
        ev_zero_len == 4'h1 && ctrl_rd_status_stage && !write && !irq_zero_len |=> !irq_zero_len;
    endproperty
    a_stage_zl: assert property (p_stage_zl) else $error("status-stage packet raised flag");
endmodule : usb_device_irq_flags_sva
bind usb_device_irq_flags usb_device_irq_flags_sva usb_device_irq_flags_sva_i (
    .core_clk, .nrst, .read, .write, .waitrequest, .readdata, .ev_ep_done, .ev_zero_len,
    .ev_nak, .ev_status_done, .ev_status_token, .ctrl_rd_status_stage, .ep_done_irq_out,
    .irq_zero_len, .irq_nak, .irq_status_done, .irq_status_token);
`default_nettype wire

// file: verification/test_usb_device_irq_flags.sv
// register-level bench of the usb interrupt flag block
// assumes the engine model drives all event inputs
`timescale 1ns/10ps
`default_nettype none
module test_usb_device_irq_flags;
    import usb_irq_flags_pkg::*;
    logic core_clk = 1'b0, nrst = 1'b0, read = 1'b0, write = 1'b0;
    logic [9:0] address = 10'h000;
    logic [3:0] byteenable = 4'hF;
    logic [31:0] writedata = 32'h0000_0000, readdata, q;
    logic waitrequest, ev_setup, ev_status_token, ev_status_done, ev_sof, ev_ep0_done, stg;
    logic [3:1] ev_ep_done, ev_nak;
    logic [3:0] ev_zero_len;
    logic [7:0] irqs;
    int num_errors = 0, n_checks = 0;
    always #50 core_clk = ~core_clk;
    usb_device_irq_flags usb_device_irq_flags_i (.core_clk, .nrst, .address, .read, .write,
        .byteenable, .writedata, .readdata, .waitrequest, .ev_setup, .ev_status_token,
        .ev_status_done, .ev_sof, .ev_ep0_done, .ev_ep_done, .ev_zero_len,
        .ctrl_rd_status_stage(stg), .ev_nak, .irq_setup(irqs[0]),
        .irq_status_token(irqs[1]), .irq_status_done(irqs[2]), .irq_zero_len(irqs[3]),
        .irq_sof(irqs[4]), .irq_ep0(irqs[5]), .ep_done_irq_out(irqs[6]), .irq_nak(irqs[7]));
    usb_engine_model usb_engine_model_i (.core_clk, .ev_setup, .ev_status_token,
        .ev_status_done, .ev_sof, .ev_ep0_done, .ev_ep_done, .ev_zero_len,
        .ctrl_rd_status_stage(stg), .ev_nak);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // one access; waitrequest is read at the edge, before that edge's updates land
    task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d);
        @(posedge core_clk);
        address <= a;
        write <= wr;
        read <= !wr;
        writedata <= d;
        do @(posedge core_clk); while (waitrequest !== 1'b0);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus
    task automatic rd(input logic [9:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        chk(q, e);
    endtask : rd
    task automatic ev(input logic [14:0] v, input logic [7:0] e);
        usb_engine_model_i.send(v);
        #1 chk({24'h0, irqs}, {24'h0, e});
    endtask : ev
    task automatic final_report;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : final_report
    // ************************************************************
    // scenarios
    // ************************************************************
    initial begin
        repeat (12) @(posedge core_clk);
        nrst <= 1'b1;
        rd(OFF_EP_MASK, 32'h0000_0001);
        bus(1'b1, 10'h100, 32'h0000_FFFF);
        rd(10'h100, 32'h0000_0000);
        rd(OFF_MAIN, 32'h0000_0000);
        ev(15'h0080, 8'h40);
        rd(OFF_EP_DONE, 32'h0000_0008);
        rd(OFF_MAIN, 32'h0000_0040);
        bus(1'b1, OFF_EP_DONE, 32'h0000_0000);
        rd(OFF_EP_DONE, 32'h0000_0008);
        bus(1'b1, OFF_EP_DONE, 32'h0000_0008);
        rd(OFF_MAIN, 32'h0000_0000);
        #1 chk({24'h0, irqs}, 32'h0000_0000);
        ev(15'h0100, 8'h00);
        rd(OFF_ZERO_LEN, 32'h0000_0001);
        bus(1'b1, OFF_EP_MASK, 32'h0000_0006);
        #1 chk({24'h0, irqs}, 32'h0000_0008);
        ev(15'h0040, 8'h08);
        rd(OFF_EP_DONE, 32'h0000_0004);
        rd(OFF_MAIN, 32'h0000_0008);
        bus(1'b1, OFF_MAIN, 32'h0000_0048);
        rd(OFF_EP_DONE, 32'h0000_0000);
        rd(OFF_ZERO_LEN, 32'h0000_0000);
        usb_engine_model_i.stage(1'b1);
        ev(15'h0100, 8'h00);
        usb_engine_model_i.stage(1'b0);
        ev(15'h1000, 8'h80);
        bus(1'b1, OFF_MAIN, 32'h0000_0080);
        rd(OFF_NAK, 32'h0000_0000);
        ev(15'h001F, 8'h37);
        rd(OFF_MAIN, 32'h0000_0037);
        bus(1'b1, OFF_MAIN, 32'h0000_4037);
        ev(15'h0080, 8'h00);
        rd(OFF_MAIN, 32'h0000_4040);
        ev(15'h2000, 8'h80);
        bus(1'b1, OFF_NAK_MASK, 32'h0000_0004);
        #1 chk({24'h0, irqs}, 32'h0000_0000);
        rd(OFF_NAK, 32'h0000_0004);
        rd(OFF_MAIN, 32'h0000_40C0);
        // mid-run reset: flags and masks return to their defaults
        @(posedge core_clk);
        nrst <= 1'b0;
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        #1 chk({24'h0, irqs}, 32'h0000_0000);
        rd(OFF_MAIN, 32'h0000_0000);
        rd(OFF_EP_MASK, 32'h0000_0001);
        final_report();
    end
    initial begin
        repeat (3000) @(posedge core_clk);
        num_errors++;
        final_report();
    end
endmodule : test_usb_device_irq_flags
`default_nettype wire
